// *** logic/usba_pkg.sv ***
package usba_pkg;

   // Character and FIFO geometry
   localparam int unsigned CHAR_W     = 8;
   localparam int unsigned FIFO_DEPTH = 16;
   localparam int unsigned CNT_W      = 5;

   // Shadow slot window, sixteen aligned words
   localparam logic [31:0] SLOT0_ADDR  = 32'h50001130;
   localparam logic [31:0] SLOT10_ADDR = 32'h50001158;
   localparam logic [31:0] SLOT11_ADDR = 32'h5000115C;
   localparam logic [31:0] SLOT_END    = 32'h50001170;

   // Control and status words
   localparam logic [31:0] STAT_ADDR = 32'h50001100;
   localparam logic [31:0] CTRL_ADDR = 32'h50001104;

   // Control fields
   localparam int unsigned CTRL_FIFO_EN_BIT = 0;
   localparam int unsigned CTRL_IR_MODE_BIT = 1;

   // Status fields
   localparam int unsigned STAT_RDY_BIT    = 0;
   localparam int unsigned STAT_OVR_BIT    = 1;
   localparam int unsigned STAT_TXE_BIT    = 5;
   localparam int unsigned STAT_TXFULL_BIT = 6;
   localparam int unsigned STAT_RXCNT_LSB  = 8;

   // Values after reset
   localparam logic [7:0] SLOT_RESET = 8'h00;
   localparam logic       FLAG_RESET = 1'h0;
   localparam logic       TXE_RESET  = 1'h1;

endpackage

// *** logic/usba_top.sv ***
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Generic synchronous FIFO with count
module usba_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   // Clock and reset
   input  wire logic                           clk,
   input  wire logic                           rst_n,
   input  wire logic                           clr,
   // Fill side
   input  wire logic                           in_valid,
   output logic                                in_ready,
   input  wire logic [WIDTH-1:0]               in_data,
   // Drain side
   output logic                                out_valid,
   input  wire logic                           out_ready,
   output logic [WIDTH-1:0]                    out_data,
   // Fill level
   output logic [$clog2(DEPTH+1)-1:0]          count
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_q [DEPTH];   // Storage
   logic [AW-1:0]    wr_ptr_q;        // Next free entry
   logic [AW-1:0]    rd_ptr_q;        // Oldest entry
   logic [CW-1:0]    count_q;         // Entries held
   wire              push;
   wire              pop;

   // Honest flags straight from the count
   assign in_ready  = (count_q != CW'(DEPTH));
   assign out_valid = (count_q != '0);
   assign out_data  = mem_q[rd_ptr_q];
   assign count     = count_q;
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Storage writes, one entry per push
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   // Pointers wrap by compare so any depth works
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else if (clr) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
         end
         count_q <= count_q + CW'(push) - CW'(pop);
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Shadow receive/transmit slots behind APB
module usba_top (
   // APB clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Received characters from the line framers
   input  wire logic        ser_rx_valid,
   input  wire logic [7:0]  ser_rx_data,
   input  wire logic        ir_rx_valid,
   input  wire logic [7:0]  ir_rx_data,
   // Characters towards the line framers
   input  wire logic        tx_ready,
   output logic             ser_tx_valid,
   output logic [7:0]       ser_tx_data,
   output logic             ir_tx_valid,
   output logic [7:0]       ir_tx_data_n,
   // Flags towards the rest of the UART
   output logic             data_ready_flag,
   output logic             tx_holding_empty_flag,
   output logic             overrun_error,
   output logic             fifo_enable,
   output logic             ir_mode
);
   localparam int unsigned CW = usba_pkg::CNT_W;
   localparam int unsigned DW = usba_pkg::CHAR_W;

   // Control and state registers
   logic          fifo_en_q;      // FIFO mode select
   logic          ir_mode_q;      // Infrared line select
   logic [DW-1:0] rx_hold_q;      // Receive holder, FIFOs off
   logic          rx_full_q;      // Receive holder full
   logic [DW-1:0] tx_hold_q;      // Transmit holder, FIFOs off
   logic          tx_empty_q;     // Transmit holder empty
   logic          overrun_q;      // Sticky overrun
   logic          overrun_d;
   logic [31:0]   prdata_q;       // Read data captured at setup
   logic [31:0]   rdata_d;

   // FIFO side signals
   logic          rxf_in_ready;
   logic          rxf_out_valid;
   logic [DW-1:0] rxf_out_data;
   logic [CW-1:0] rxf_count;
   logic          txf_in_ready;
   logic          txf_out_valid;
   logic [DW-1:0] txf_out_data;
   logic [CW-1:0] txf_count;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode and access strobes
   wire slot_hit = (paddr >= usba_pkg::SLOT0_ADDR) &&
                   (paddr <  usba_pkg::SLOT_END) &&
                   (paddr[1:0] == 2'h0);
   wire stat_hit = (paddr == usba_pkg::STAT_ADDR);
   wire ctrl_hit = (paddr == usba_pkg::CTRL_ADDR);
   wire any_hit  = slot_hit | stat_hit | ctrl_hit;
   wire setup    = psel & ~penable;
   wire access   = psel & penable;
   wire wr_slot  = access & pwrite & slot_hit;
   wire rd_slot  = access & ~pwrite & slot_hit;
   wire wr_ctrl  = access & pwrite & ctrl_hit;
   wire rd_stat  = access & ~pwrite & stat_hit;

   // Zero wait: read data was already captured in setup
   assign pready  = 1'b1;
   assign pslverr = access & ~any_hit;
   assign prdata  = prdata_q;

   // Changing FIFO mode empties both paths so no stale char leaks
   wire new_fifo_en = pwdata[usba_pkg::CTRL_FIFO_EN_BIT];
   wire fifo_clr    = wr_ctrl & (new_fifo_en != fifo_en_q);

   ////////////////////////////////////////////////////////////////////////////
   // Receive source select by line mode
   wire          rx_valid = ir_mode_q ? ir_rx_valid : ser_rx_valid;
   wire [DW-1:0] rx_data  = ir_mode_q ? ir_rx_data : ser_rx_data;

   // Receive FIFO: arrivals are never stalled, a full FIFO drops them
   usba_fifo #(
      .WIDTH (usba_pkg::CHAR_W),
      .DEPTH (usba_pkg::FIFO_DEPTH)
   ) u_rx_fifo (
      .clk       (pclk),
      .rst_n     (presetn),
      .clr       (fifo_clr),
      .in_valid  (fifo_en_q & rx_valid),
      .in_ready  (rxf_in_ready),
      .in_data   (rx_data),
      .out_valid (rxf_out_valid),
      .out_ready (fifo_en_q & rd_slot),
      .out_data  (rxf_out_data),
      .count     (rxf_count)
   );

   // Transmit FIFO: line back-pressure via tx_ready fills it
   usba_fifo #(
      .WIDTH (usba_pkg::CHAR_W),
      .DEPTH (usba_pkg::FIFO_DEPTH)
   ) u_tx_fifo (
      .clk       (pclk),
      .rst_n     (presetn),
      .clr       (fifo_clr),
      .in_valid  (fifo_en_q & wr_slot),
      .in_ready  (txf_in_ready),
      .in_data   (pwdata[DW-1:0]),
      .out_valid (txf_out_valid),
      .out_ready (fifo_en_q & tx_ready),
      .out_data  (txf_out_data),
      .count     (txf_count)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Overrun: holder still full, or receive FIFO full, when a char lands
   wire ovr_set = rx_valid & (fifo_en_q ? ~rxf_in_ready
                                        : (rx_full_q & ~rd_slot));
   // Set wins over the status-read clear
   assign overrun_d = ovr_set | (overrun_q & ~rd_stat);

   // Transmit character select and line outputs
   wire          tx_any   = fifo_en_q ? txf_out_valid : ~tx_empty_q;
   wire [DW-1:0] tx_char  = fifo_en_q ? txf_out_data : tx_hold_q;
   assign ser_tx_valid    = tx_any & ~ir_mode_q;
   assign ir_tx_valid     = tx_any & ir_mode_q;
   assign ser_tx_data     = tx_char;
   assign ir_tx_data_n    = ~tx_char;

   // Flags towards the rest of the UART; master relies on them
   assign data_ready_flag       = fifo_en_q ? rxf_out_valid : rx_full_q;
   // Master trusts slot data only with data ready set
   assign tx_holding_empty_flag = fifo_en_q ? (txf_count == '0)
                                            : tx_empty_q;
   assign overrun_error         = overrun_q;
   assign fifo_enable           = fifo_en_q;
   assign ir_mode               = ir_mode_q;

   // Read mux; upper slot bits are always zero
   wire [DW-1:0] rd_char = fifo_en_q ? rxf_out_data : rx_hold_q;
   always_comb begin
      rdata_d = 32'h00000000;
      if (slot_hit) begin
         rdata_d[DW-1:0] = rd_char;
      end else if (stat_hit) begin
         rdata_d[usba_pkg::STAT_RDY_BIT]    = data_ready_flag;
         rdata_d[usba_pkg::STAT_OVR_BIT]    = overrun_q;
         rdata_d[usba_pkg::STAT_TXE_BIT]    = tx_holding_empty_flag;
         rdata_d[usba_pkg::STAT_TXFULL_BIT] = ~txf_in_ready;
         rdata_d[usba_pkg::STAT_RXCNT_LSB +: CW] = rxf_count;
      end else if (ctrl_hit) begin
         rdata_d[usba_pkg::CTRL_FIFO_EN_BIT] = fifo_en_q;
         rdata_d[usba_pkg::CTRL_IR_MODE_BIT] = ir_mode_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data capture in setup; pops happen only at access end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h00000000;
      end else if (setup) begin
         prdata_q <= rdata_d;
      end
   end

   // Control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_en_q <= usba_pkg::FLAG_RESET;
         ir_mode_q <= usba_pkg::FLAG_RESET;
      end else if (wr_ctrl) begin
         fifo_en_q <= new_fifo_en;
         ir_mode_q <= pwdata[usba_pkg::CTRL_IR_MODE_BIT];
      end
   end

   // Receive holder, FIFOs off: newest character wins, except in a mode-change clear cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_hold_q <= usba_pkg::SLOT_RESET;
         rx_full_q <= usba_pkg::FLAG_RESET;
      end else if (fifo_clr) begin
         rx_full_q <= 1'b0;
      end else if (!fifo_en_q && rx_valid) begin
         rx_hold_q <= rx_data;
         rx_full_q <= 1'b1;
      end else if (!fifo_en_q && rd_slot) begin
         rx_full_q <= 1'b0;
      end
   end

   // Transmit holder, FIFOs off: a write beats a same-cycle line take
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_hold_q  <= usba_pkg::SLOT_RESET;
         tx_empty_q <= usba_pkg::TXE_RESET;
      end else if (fifo_clr) begin
         tx_empty_q <= 1'b1;
      end else if (!fifo_en_q && wr_slot) begin
         tx_hold_q  <= pwdata[DW-1:0];
         tx_empty_q <= 1'b0;
      end else if (!fifo_en_q && !tx_empty_q && tx_ready) begin
         tx_empty_q <= 1'b1;
      end
   end

   // Sticky overrun
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overrun_q <= usba_pkg::FLAG_RESET;
      end else begin
         overrun_q <= overrun_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_rx_char_path: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!fifo_en_q && !fifo_clr && ir_mode_q && ir_rx_valid)
      |=> (rx_hold_q == $past(ir_rx_data)) && rx_full_q)
      else $error("infrared character not held");

   a_ovr_overwrite: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!fifo_en_q && !fifo_clr && rx_full_q && rx_valid && !rd_slot)
      |=> overrun_q && (rx_hold_q == $past(rx_data)))
      else $error("overwrite without overrun");

   a_fifo_head_read: assert property (
      @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && slot_hit && fifo_en_q)
      |=> prdata[7:0] == $past(rxf_out_data))
      else $error("slot read not FIFO head");

   a_full_rx_drop: assert property (
      @(posedge pclk) disable iff (!presetn)
      (fifo_en_q && rx_valid && !rd_slot && !fifo_clr &&
       rxf_count == CW'(usba_pkg::FIFO_DEPTH))
      |=> overrun_q && (rxf_count == $past(rxf_count)))
      else $error("full receive FIFO changed");

   a_slot_alias: assert property (
      @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && slot_hit && !fifo_en_q)
      |=> prdata == {24'h000000, $past(rx_hold_q)})
      else $error("slot does not alias holder");

   a_ir_tx_low: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_slot && !fifo_en_q && ir_mode_q)
      |=> ir_tx_valid && !ser_tx_valid &&
          (ir_tx_data_n == ~$past(pwdata[7:0])))
      else $error("infrared output not inverted char");

   a_tx_empty_clear: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_slot && !fifo_en_q) |=> !tx_holding_empty_flag)
      else $error("holding-empty not cleared");

   a_tx_replace: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_slot && !fifo_en_q && !tx_empty_q)
      |=> ser_tx_data == $past(pwdata[7:0]))
      else $error("pending char not replaced");

   a_tx_depth: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_slot && fifo_en_q && !tx_ready &&
       txf_count < CW'(usba_pkg::FIFO_DEPTH))
      |=> txf_count == $past(txf_count) + 5'h01)
      else $error("write below depth not accepted");

   a_full_tx_drop: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_slot && fifo_en_q && !tx_ready &&
       txf_count == CW'(usba_pkg::FIFO_DEPTH))
      |=> $stable(txf_count) && $stable(txf_out_data))
      else $error("full transmit FIFO changed");

   a_upper_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      (access && !pwrite && slot_hit) |-> prdata[31:8] == 24'h000000)
      else $error("slot upper bits not zero");

endmodule

// *** tb/usba_line_model.sv ***
`timescale 1ns/1ps

////////////////////////////////////////////////////////////
// Line-side framer model: feeds received chars, takes sent ones
module usba_line_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Pacing set by the bench
   input  wire logic       stall,
   input  wire logic       slow,
   // Received characters towards the block
   output logic            ser_rx_valid,
   output logic [7:0]      ser_rx_data,
   output logic            ir_rx_valid,
   output logic [7:0]      ir_rx_data,
   // Transmitted characters from the block
   output logic            tx_ready,
   input  wire logic       ser_tx_valid,
   input  wire logic [7:0] ser_tx_data,
   input  wire logic       ir_tx_valid,
   input  wire logic [7:0] ir_tx_data_n
);
   logic [8:0] got[$];  // Taken chars, bit 8 marks the infrared path

   // Idle data lines never hold a meaningful value
   initial begin
      ser_rx_valid = 1'b0;
      ser_rx_data  = 8'hA5;
      ir_rx_valid  = 1'b0;
      ir_rx_data   = 8'h5A;
   end

   // One char per call; data scrambled after it so stale bytes show
   task automatic rx_char(input logic ir, input logic [7:0] d);
      if (ir) begin
         ir_rx_valid <= 1'b1;
         ir_rx_data  <= d;
      end else begin
         ser_rx_valid <= 1'b1;
         ser_rx_data  <= d;
      end
      @(posedge clk);
      ir_rx_valid  <= 1'b0;
      ser_rx_valid <= 1'b0;
      ir_rx_data   <= ~d;
      ser_rx_data  <= ~d;
      @(posedge clk);
   endtask

   // Ready: prompt, every other cycle when slow, low when stalled
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) tx_ready <= 1'b0;
      else tx_ready <= !stall && (!slow || !tx_ready);
   end

   // Collect each char handed over, infrared undone from active low
   always @(posedge clk) begin
      if (rst_n && tx_ready) begin
         if (ser_tx_valid) got.push_back({1'b0, ser_tx_data});
         if (ir_tx_valid) got.push_back({1'b1, ~ir_tx_data_n});
      end
   end
endmodule

// *** tb/uart_shadow_buffer_access_tb.sv ***
`timescale 1ns/1ps

////////////////////////////////////////////////////////////
// Bench for the shadow slots: APB master plus line model
module uart_shadow_buffer_access_tb;
   localparam logic [31:0] ST = usba_pkg::STAT_ADDR;   // Status word
   localparam logic [31:0] CT = usba_pkg::CTRL_ADDR;   // Control word
   localparam logic [31:0] S0 = usba_pkg::SLOT0_ADDR;  // First slot
   localparam logic [31:0] M  = 32'hFFFFFFFF;          // Full mask

   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic        ser_rx_valid, ir_rx_valid, tx_ready, ser_tx_valid;
   logic        ir_tx_valid, stall, slow, err;
   logic [7:0]  ser_rx_data, ir_rx_data, ser_tx_data, ir_tx_data_n;
   logic        data_ready_flag, tx_holding_empty_flag, overrun_error;
   logic        fifo_enable, ir_mode;
   int          fail_count, total_checks;

   usba_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .ser_rx_valid(ser_rx_valid), .ser_rx_data(ser_rx_data),
      .ir_rx_valid(ir_rx_valid), .ir_rx_data(ir_rx_data),
      .tx_ready(tx_ready), .ser_tx_valid(ser_tx_valid),
      .ser_tx_data(ser_tx_data), .ir_tx_valid(ir_tx_valid),
      .ir_tx_data_n(ir_tx_data_n), .data_ready_flag(data_ready_flag),
      .tx_holding_empty_flag(tx_holding_empty_flag),
      .overrun_error(overrun_error), .fifo_enable(fifo_enable),
      .ir_mode(ir_mode));

   usba_line_model line (.clk(pclk), .rst_n(presetn), .stall(stall),
      .slow(slow), .ser_rx_valid(ser_rx_valid), .ser_rx_data(ser_rx_data),
      .ir_rx_valid(ir_rx_valid), .ir_rx_data(ir_rx_data),
      .tx_ready(tx_ready), .ser_tx_valid(ser_tx_valid),
      .ser_tx_data(ser_tx_data), .ir_tx_valid(ir_tx_valid),
      .ir_tx_data_n(ir_tx_data_n));

   // 200 MHz clock
   initial pclk = 1'b0;
   always #2.5 pclk = ~pclk;

   // Verdict and end of run, the only exit
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // Compare one value, four-state exact
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      if (n >= 64) begin
         fail_count++;
         print_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Read and compare under a mask
   task automatic rdchk(input logic [31:0] a, input logic [31:0] mask,
                        input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd & mask, exp);
   endtask

   // Bounded wait for chars at the line
   task automatic wait_tx(input int n);
      int k;
      k = 0;
      while (line.got.size() < n && k < 500) begin
         @(posedge pclk);
         k++;
      end
      if (k >= 500) begin
         fail_count++;
         print_verdict();
      end
      repeat (8) @(posedge pclk);
   endtask

   // Hang guard
   initial begin
      repeat (40000) @(posedge pclk);
      fail_count++;
      print_verdict();
   end

   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      stall = 1'b0;
      slow = 1'b0;
      fail_count = 0;
      total_checks = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Reset values and an unmapped word
      rdchk(ST, 32'h63, 32'h20);
      rdchk(CT, M, 32'h0);
      rdchk(usba_pkg::SLOT10_ADDR, M, 32'h0);
      apb(1'b0, usba_pkg::SLOT_END, 32'h0);
      chk({31'h0, err}, 32'h1);
      $display("Test reset done");
      // FIFOs off: read, then overwrite with overrun
      line.rx_char(1'b0, 8'h55);
      chk({31'h0, data_ready_flag}, 32'h1);
      rdchk(ST, 32'h1, 32'h1);
      rdchk(usba_pkg::SLOT10_ADDR, M, 32'h55);
      line.rx_char(1'b0, 8'h41);
      line.rx_char(1'b0, 8'h42);
      chk({31'h0, overrun_error}, 32'h1);
      rdchk(ST, 32'h3, 32'h3);
      rdchk(usba_pkg::SLOT11_ADDR, M, 32'h42);
      rdchk(ST, 32'h3, 32'h0);
      $display("Test overwrite done");
      // Infrared mode: only the infrared input counts, output inverted
      apb(1'b1, CT, 32'h2);
      chk({30'h0, fifo_enable, ir_mode}, 32'h1);
      line.rx_char(1'b1, 8'h9C);
      line.rx_char(1'b0, 8'h77);
      rdchk(usba_pkg::SLOT11_ADDR, M, 32'h9C);
      rdchk(ST, 32'h1, 32'h0);
      line.got.delete();
      chk({31'h0, tx_holding_empty_flag}, 32'h1);
      apb(1'b1, usba_pkg::SLOT10_ADDR, 32'h1A5);
      wait_tx(1);
      chk({23'h0, line.got[0]}, 32'h1A5);
      $display("Test infrared done");
      // FIFOs off transmit with the line stalled
      apb(1'b1, CT, 32'h0);
      stall <= 1'b1;
      line.got.delete();
      chk({31'h0, tx_holding_empty_flag}, 32'h1);
      apb(1'b1, S0, 32'h11);
      chk({31'h0, tx_holding_empty_flag}, 32'h0);
      rdchk(ST, 32'h20, 32'h0);
      apb(1'b1, S0 + 32'h4, 32'h22);
      stall <= 1'b0;
      wait_tx(1);
      chk(line.got.size(), 32'h1);
      chk({23'h0, line.got[0]}, 32'h22);
      chk({31'h0, tx_holding_empty_flag}, 32'h1);
      $display("Test holder done");
      // FIFOs on: fill past full, drain over all sixteen slots
      apb(1'b1, CT, 32'h1);
      chk({30'h0, fifo_enable, ir_mode}, 32'h2);
      for (int i = 0; i < 17; i++) line.rx_char(1'b0, 8'h30 + i[7:0]);
      rdchk(ST, 32'h1F03, 32'h1003);
      for (int i = 0; i < 16; i++) begin
         rdchk(S0 + 32'(4 * i), M, 32'h30 + 32'(i));
      end
      rdchk(ST, 32'h1, 32'h0);
      $display("Test receive fifo done");
      // FIFOs on transmit: write past full, then slow drain
      stall <= 1'b1;
      line.got.delete();
      chk({31'h0, tx_holding_empty_flag}, 32'h1);
      // Seventeenth write wraps to slot 0 and meets a full FIFO
      for (int i = 0; i < 17; i++) begin
         apb(1'b1, S0 + 32'(4 * (i % 16)), 32'h60 + i);
      end
      rdchk(ST, 32'h60, 32'h40);
      stall <= 1'b0;
      slow <= 1'b1;
      wait_tx(16);
      chk(line.got.size(), 32'd16);
      for (int i = 0; i < 16; i++) begin
         chk({23'h0, line.got[i]}, 32'h60 + 32'(i));
      end
      $display("Test transmit fifo done");
      print_verdict();
   end
endmodule
